// ==== burst_sram_pkg.sv ====
// Shared widths, encodings and timing constants for the burst memory link
package burst_sram_pkg;
	localparam int ADDR_W        = 12;
	localparam int LANES         = 4;
	localparam int LANE_W        = 8;
	localparam int DATA_W        = LANES * LANE_W;
	localparam int BURST_LEN     = 4;
	localparam int FIFO_DEPTH    = 16;
	localparam int SLEEP_CYCLES  = 2;
	localparam logic [1:0] BURST_LO_MASK = 2'h3;
	localparam logic [1:0] BEAT_ZERO     = 2'h0;
	localparam logic [1:0] BEAT_ONE      = 2'h1;
	localparam logic       ORDER_LINEAR  = 1'b0;
	localparam logic       ORDER_INTLV   = 1'b1;

	typedef enum logic [1:0] {
		CMD_IDLE  = 2'h0,
		CMD_READ  = 2'h1,
		CMD_WRITE = 2'h2
	} cmd_t;

	typedef enum logic [1:0] {
		HS_IDLE  = 2'b00,
		HS_ISSUE = 2'b01,
		HS_BURST = 2'b11
	} host_state_t;

	// Low two address bits of a burst beat
	function automatic logic [1:0] burst_addr(input logic [1:0] start,
		input logic [1:0] beat, input logic order);
		burst_addr = (order == ORDER_INTLV) ? (start ^ beat)
			: 2'(start + beat);
	endfunction
endpackage

// ==== burst_sram_if.sv ====
// Pin-level interface between the bus master and the burst memory
`timescale 1ns/1ps
interface burst_sram_if;
	import burst_sram_pkg::*;
	logic                clock_qualifier_n;
	logic                chip_select_1_n;
	logic                chip_select_2;
	logic                chip_select_3_n;
	logic                advance_load;
	logic                write_n;
	logic [LANES-1:0]    byte_write_strobe_n;
	logic                output_enable_n;
	logic                sleep_request;
	logic                burst_order;
	logic [ADDR_W-1:0]   addr;
	logic [DATA_W-1:0]   mem_dq_o;
	logic [LANES-1:0]    mem_par_o;
	logic                mem_oe_n;
	logic [DATA_W-1:0]   host_dq_o;
	logic [LANES-1:0]    host_par_o;
	logic                host_oe_n;
	wire  [DATA_W-1:0]   dq = !mem_oe_n ? mem_dq_o
		: (!host_oe_n ? host_dq_o : '0);
	wire  [LANES-1:0]    parity_lines = !mem_oe_n ? mem_par_o
		: (!host_oe_n ? host_par_o : '0);

	modport memory (
		input  clock_qualifier_n, chip_select_1_n, chip_select_2,
		input  chip_select_3_n, advance_load, write_n,
		input  byte_write_strobe_n, output_enable_n, sleep_request,
		input  burst_order, addr, dq, parity_lines,
		output mem_dq_o, mem_par_o, mem_oe_n
	);
	modport host (
		output clock_qualifier_n, chip_select_1_n, chip_select_2,
		output chip_select_3_n, advance_load, write_n,
		output byte_write_strobe_n, output_enable_n, sleep_request,
		output burst_order, addr, host_dq_o, host_par_o, host_oe_n,
		input  dq, parity_lines
	);
endinterface

// ==== burst_fifo.sv ====
// Parameterised valid/ready FIFO
`timescale 1ns/1ps
module burst_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             mclk,
	input  wire logic             resetn,
	input  wire logic             ce,
	input  wire logic             in_valid,
	output      logic             in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output      logic             out_valid,
	input  wire logic             out_ready,
	output      logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] store [DEPTH];
	logic [PW-1:0]    wr_r;
	logic [PW-1:0]    rd_r;
	logic [PW:0]      cnt_r;
	wire              push = ce && in_valid && in_ready;
	wire              pop  = ce && out_valid && out_ready;

	assign in_ready  = (cnt_r != (PW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign out_data  = store[rd_r];

	always_ff @(posedge mclk) begin
		if (push)
			store[wr_r] <= in_data;
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			wr_r  <= '0;
			rd_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push)
				wr_r <= (wr_r == PW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
			if (pop)
				rd_r <= (rd_r == PW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
			cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule // burst_fifo

// ==== burst_sram_mem.sv ====
// Pipelined burst memory end: input registers, burst counter, output pipe
//
// Behaviour
// - Synchronous inputs registered on rising clock
// - Qualifier high after its first low holds the input registers, not the pipeline
// - Read data comes from output register
// - All selects asserted (select 2 high, others low) and load low start access
// - Write strobe high reads, low writes
// - Byte strobes select written lanes
// - Read data appears two edges after capture
// - Output enable plus internal control drive outputs
// - Next operation may start in second clock
// - Deselect tri-states outputs two edges after capture
// - Master reloads address after deselect
// - Burst counter allows four beats per address
// - Order strap low linear, high interleaved
// - Bursts wrap within the low two bits
// - Advance high steps counter, ignores selects
// - Direction kept for whole burst
// - Sleep input idles memory, keeps data
// - Test select sampled on test clock
// - Writes self-timed, no extra pulse
// - Outputs masked during write data, deselect
// - Order strap sampled while no burst is active, defaults interleaved
// - Write data latched three edges after address
// - Qualifier high after its first low re-applies the held command each edge
`timescale 1ns/1ps
module burst_sram_mem
	import burst_sram_pkg::*;
#(
	parameter int WORDS = 1 << ADDR_W
) (
	input  wire logic   mclk,
	input  wire logic   resetn,
	input  wire logic   ce,
	input  wire logic   test_clk,
	input  wire logic   test_mode_select,
	output      logic   sleeping,
	output      logic [3:0] test_state,
	burst_sram_if.memory bus
);
	import burst_sram_pkg::*;

	logic [DATA_W-1:0] mem [WORDS];
	logic [LANES-1:0]  par [WORDS];

	// Input registers
	logic              cq_n_r;
	logic              sel_r, adv_r, wr_n_r;
	logic [LANES-1:0]  bws_n_r;
	logic [ADDR_W-1:0] addr_r;
	logic              order_r;
	// Access pipeline
	logic [ADDR_W-1:0] base_r;
	logic [1:0]        beat_r;
	logic              dir_wr_r;
	logic              active_r;
	logic              rd_p1_r, wr_p1_r, wr_p2_r;
	logic [ADDR_W-1:0] wa_p1_r, wa_p2_r;
	logic [LANES-1:0]  bw_p1_r, bw_p2_r;
	logic [DATA_W-1:0] q_r;
	logic [LANES-1:0]  qp_r;
	logic              drive_r;
	logic [1:0]        sleep_cnt_r;
	logic [3:0]        tap_r;

	wire run = ce && !cq_n_r && !sleeping;
	wire sel_now = !bus.chip_select_1_n && bus.chip_select_2
		&& !bus.chip_select_3_n;
	wire start  = run && !adv_r && sel_r;
	wire desel  = run && !adv_r && !sel_r;
	wire step   = run && adv_r && active_r;
	wire [1:0] next_beat = step ? 2'(beat_r + BEAT_ONE) : BEAT_ZERO;
	wire [1:0] lo = burst_addr(start ? addr_r[1:0] : base_r[1:0],
		next_beat, order_r);
	wire [ADDR_W-1:0] hi_base = start ? addr_r : base_r;
	wire [ADDR_W-1:0] cur_addr = {hi_base[ADDR_W-1:2], lo};
	wire beat_wr = start ? !wr_n_r : dir_wr_r;
	wire beat_go = start || step;

	// capture pins on enabled edges with qualifier low, or any enabled edge until the first low; high later holds them
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cq_n_r  <= 1'b1;
			sel_r   <= 1'b0;
			adv_r   <= 1'b0;
			wr_n_r  <= 1'b1;
			bws_n_r <= '1;
			addr_r  <= '0;
		end else if (ce && (bus.clock_qualifier_n == 1'b0 || cq_n_r)) begin
			cq_n_r  <= bus.clock_qualifier_n;
			sel_r   <= sel_now;
			adv_r   <= bus.advance_load;
			wr_n_r  <= bus.write_n;
			bws_n_r <= bus.byte_write_strobe_n;
			addr_r  <= bus.addr;
		end
	end

	// Strap sampled on every enabled edge while no burst is active
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			order_r <= ORDER_INTLV;
		else if (ce && !active_r)
			order_r <= bus.burst_order;
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			base_r   <= '0;
			beat_r   <= BEAT_ZERO;
			dir_wr_r <= 1'b0;
			active_r <= 1'b0;
		end else if (run) begin
			if (start) begin
				base_r   <= addr_r;
				dir_wr_r <= !wr_n_r;
			end
			if (start || desel)
				active_r <= start;
			beat_r <= next_beat;
		end
	end

	// Read two edges after capture, write three edges after capture
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rd_p1_r <= 1'b0;
			wr_p1_r <= 1'b0;
			wr_p2_r <= 1'b0;
			wa_p1_r <= '0;
			wa_p2_r <= '0;
			bw_p1_r <= '1;
			bw_p2_r <= '1;
			drive_r <= 1'b0;
			q_r     <= '0;
			qp_r    <= '0;
		end else if (run) begin
			rd_p1_r <= beat_go && !beat_wr;
			wr_p1_r <= beat_go && beat_wr;
			wa_p1_r <= cur_addr;
			bw_p1_r <= bws_n_r;
			wr_p2_r <= wr_p1_r;
			wa_p2_r <= wa_p1_r;
			bw_p2_r <= bw_p1_r;
			drive_r <= rd_p1_r;
			if (rd_p1_r) begin
				q_r  <= mem[wa_p1_r];
				qp_r <= par[wa_p1_r];
			end
		end
	end

	// Self-timed write: the lane update needs no pulse from the master
	always_ff @(posedge mclk) begin
		if (run && wr_p2_r) begin
			for (int i = 0; i < LANES; i++) begin
				if (!bw_p2_r[i]) begin
					mem[wa_p2_r][i*LANE_W +: LANE_W] <=
						bus.dq[i*LANE_W +: LANE_W];
					par[wa_p2_r][i] <= bus.parity_lines[i];
				end
			end
		end
	end

	// Sleep entry takes two clocks; stored words are untouched
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			sleep_cnt_r <= '0;
		else if (ce) begin
			if (!bus.sleep_request)
				sleep_cnt_r <= '0;
			else if (sleep_cnt_r != 2'(SLEEP_CYCLES))
				sleep_cnt_r <= sleep_cnt_r + 1'b1;
		end
	end
	assign sleeping = (sleep_cnt_r == 2'(SLEEP_CYCLES));

	// Minimal test port walker: state advances by the select level
	always_ff @(posedge test_clk or negedge resetn) begin
		if (!resetn)
			tap_r <= '0;
		else
			tap_r <= test_mode_select ? 4'(tap_r + 1'b1) : '0;
	end
	assign test_state = tap_r;

	// Pin drives low enable only while a read word is out and OE is low
	assign bus.mem_oe_n  = !(drive_r && !bus.output_enable_n);
	assign bus.mem_dq_o  = q_r;
	assign bus.mem_par_o = qp_r;
endmodule // burst_sram_mem

// ==== burst_sram_host.sv ====
// Bus master end: takes commands from a FIFO, drives pins, returns read data
`timescale 1ns/1ps
module burst_sram_host
	import burst_sram_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              resetn,
	input  wire logic              ce,
	input  wire logic              cmd_valid,
	output      logic              cmd_ready,
	input  wire logic              cmd_write,
	input  wire logic [ADDR_W-1:0] cmd_addr,
	input  wire logic [DATA_W-1:0] cmd_wdata,
	input  wire logic [LANES-1:0]  cmd_bytes,
	input  wire logic              order_sel,
	input  wire logic              sleep_in,
	output      logic              rd_valid,
	output      logic [DATA_W-1:0] rd_data,
	burst_sram_if.host             bus
);
	import burst_sram_pkg::*;
	localparam int CW = 1 + ADDR_W + DATA_W + LANES;

	logic          f_valid;
	logic          f_ready;
	logic [CW-1:0] f_data;
	logic [3:0]    rd_pipe_r;
	logic [DATA_W-1:0] wd_p1_r, wd_p2_r, wd_p3_r, wd_p4_r;
	logic [3:0]    wr_pipe_r;
	logic          issue_r, wr_r;
	logic [ADDR_W-1:0] a_r;
	logic [LANES-1:0]  bw_r;
	logic          rdv_r;
	logic [DATA_W-1:0] rdd_r;

	burst_fifo #(.WIDTH(CW), .DEPTH(FIFO_DEPTH)) u_cmd_fifo (
		.mclk      (mclk),
		.resetn    (resetn),
		.ce        (ce),
		.in_valid  (cmd_valid),
		.in_ready  (cmd_ready),
		.in_data   ({cmd_write, cmd_addr, cmd_wdata, cmd_bytes}),
		.out_valid (f_valid),
		.out_ready (f_ready),
		.out_data  (f_data)
	);

	// Single accesses only; every access reloads the address
	assign f_ready = !sleep_in;
	wire take = ce && f_valid && f_ready;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			issue_r   <= 1'b0;
			wr_r      <= 1'b0;
			a_r       <= '0;
			bw_r      <= '1;
			rd_pipe_r <= '0;
			wr_pipe_r <= '0;
			wd_p1_r   <= '0;
			wd_p2_r   <= '0;
			wd_p3_r   <= '0;
			wd_p4_r   <= '0;
			rdv_r     <= 1'b0;
			rdd_r     <= '0;
		end else if (ce) begin
			issue_r   <= take;
			wr_r      <= take && f_data[CW-1];
			a_r       <= f_data[CW-2 -: ADDR_W];
			bw_r      <= ~f_data[LANES-1:0];
			wd_p1_r   <= f_data[LANES +: DATA_W];
			wd_p2_r   <= wd_p1_r;
			wd_p3_r   <= wd_p2_r;
			wd_p4_r   <= wd_p3_r;
			// Memory adds an input register, so data slots trail by four
			rd_pipe_r <= {rd_pipe_r[2:0], take && !f_data[CW-1]};
			wr_pipe_r <= {wr_pipe_r[2:0], take && f_data[CW-1]};
			rdv_r     <= rd_pipe_r[3];
			rdd_r     <= bus.dq;
		end
	end

	assign bus.clock_qualifier_n   = !ce;
	assign bus.chip_select_1_n     = !issue_r;
	assign bus.chip_select_2       = issue_r;
	assign bus.chip_select_3_n     = !issue_r;
	assign bus.advance_load        = 1'b0;
	assign bus.write_n             = !wr_r;
	assign bus.byte_write_strobe_n = bw_r;
	assign bus.output_enable_n     = wr_pipe_r[3];
	assign bus.sleep_request       = sleep_in;
	assign bus.burst_order         = order_sel;
	assign bus.addr                = a_r;
	// Data valid on the edge three clocks after the capture edge
	assign bus.host_dq_o           = wd_p4_r;
	assign bus.host_par_o          = '0;
	assign bus.host_oe_n           = !wr_pipe_r[3];
	assign rd_valid                = rdv_r;
	assign rd_data                 = rdd_r;
endmodule // burst_sram_host

// ==== burst_sram_checker.sv ====
// Pin-level assertions between the bus master and the burst memory
`timescale 1ns/1ps
module burst_sram_checker
	import burst_sram_pkg::*;
(
	input wire logic              mclk,
	input wire logic              resetn,
	input wire logic              clock_qualifier_n,
	input wire logic              chip_select_1_n,
	input wire logic              chip_select_2,
	input wire logic              chip_select_3_n,
	input wire logic              advance_load,
	input wire logic              write_n,
	input wire logic              output_enable_n,
	input wire logic              sleep_request,
	input wire logic [DATA_W-1:0] mem_dq_o,
	input wire logic              mem_oe_n,
	input wire logic              host_oe_n
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	wire logic sel = !chip_select_1_n && chip_select_2 && !chip_select_3_n;
	wire logic go = sel && !clock_qualifier_n && !advance_load;
	wire logic wr_go = go && !write_n;
	sequence s_rd; go && write_n && !output_enable_n; endsequence
	sequence s_wr; wr_go; endsequence
	sequence s_idle; (!clock_qualifier_n && !sel)[*5]; endsequence
	property p_rd_drive; s_rd |-> ##[1:4] !mem_oe_n; endproperty
	a_rd_drive: assert property (p_rd_drive)
		else $error("read data not driven");
	property p_wr_data; s_wr |-> ##[1:4] !host_oe_n; endproperty
	a_wr_data: assert property (p_wr_data)
		else $error("write data not presented");
	property p_no_fight; !(!mem_oe_n && !host_oe_n); endproperty
	a_no_fight: assert property (p_no_fight)
		else $error("both ends drive the data lines");
	property p_desel; s_idle |-> mem_oe_n; endproperty
	a_desel: assert property (p_desel)
		else $error("deselected memory still drives");
	property p_oe_gate; output_enable_n[*3] |-> mem_oe_n; endproperty
	a_oe_gate: assert property (p_oe_gate)
		else $error("memory drives with output enable high");
	property p_freeze; clock_qualifier_n[*2] |=> $stable(mem_dq_o); endproperty
	a_freeze: assert property (p_freeze)
		else $error("output register moved while frozen");
	// Host data must belong to a write that started a few edges before
	property p_host_src;
		!host_oe_n |-> $past(wr_go, 1) || $past(wr_go, 2)
			|| $past(wr_go, 3) || $past(wr_go, 4);
	endproperty
	a_host_src: assert property (p_host_src)
		else $error("host drives data outside a write");
	property p_sleep; sleep_request[*3] |-> !go; endproperty
	a_sleep: assert property (p_sleep)
		else $error("access started while asleep");
	c_rd: cover property (s_rd ##1 s_rd);
endmodule // burst_sram_checker

// ==== pipelined_burst_sram_access_tb.sv ====
// Testbench: master and memory joined, commands in, read data compared
`timescale 1ns/1ps
module pipelined_burst_sram_access_tb;
	import burst_sram_pkg::*;
	typedef struct packed {
		logic              w;
		logic [ADDR_W-1:0] a;
		logic [DATA_W-1:0] d;
		logic [LANES-1:0]  b;
	} row_t;
	// Reads carry the expected word left by the earlier writes to their address
	row_t rows [7] = '{
		'{1'b1, 12'h000, 32'h1111_2222, 4'hF},
		'{1'b1, 12'hFFF, 32'h3333_4444, 4'hF},
		'{1'b1, 12'h000, 32'hAAAA_BBBB, 4'h5},
		'{1'b1, 12'h555, 32'h5A5A_C3C3, 4'hF},
		'{1'b0, 12'hFFF, 32'h3333_4444, 4'h0},
		'{1'b0, 12'h000, 32'h11AA_22BB, 4'h0},
		'{1'b0, 12'h555, 32'h5A5A_C3C3, 4'h0}};
	logic              mclk, resetn, ce, cmd_valid, cmd_ready, cmd_write;
	logic              order_sel, sleep_in, rd_valid, sleeping;
	logic              test_clk, test_mode_select;
	logic [ADDR_W-1:0] cmd_addr;
	logic [DATA_W-1:0] cmd_wdata, rd_data, v;
	logic [LANES-1:0]  cmd_bytes;
	logic [3:0]        test_state;
	logic [DATA_W-1:0] rdq[$];
	int                errors, n_tests, cyc, k;
	burst_sram_if pins();
	burst_sram_mem u_burst_sram_mem(.*, .bus(pins));
	burst_sram_host u_burst_sram_host(.*, .bus(pins));
	burst_sram_checker u_burst_sram_checker(.mclk(mclk), .resetn(resetn),
		.clock_qualifier_n(pins.clock_qualifier_n),
		.chip_select_1_n(pins.chip_select_1_n),
		.chip_select_2(pins.chip_select_2),
		.chip_select_3_n(pins.chip_select_3_n),
		.advance_load(pins.advance_load), .write_n(pins.write_n),
		.output_enable_n(pins.output_enable_n),
		.sleep_request(pins.sleep_request), .mem_dq_o(pins.mem_dq_o),
		.mem_oe_n(pins.mem_oe_n), .host_oe_n(pins.host_oe_n));
	initial begin
		mclk = 0;
		forever #25 mclk = ~mclk;
	end
	always @(negedge mclk) if (rd_valid === 1'b1) rdq.push_back(rd_data);
	// Watchdog: the whole run needs under a hundred cycles
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			end_sim();
		end
	end
	task automatic chk(input string n, input logic [31:0] e, s);
		n_tests++;
		if (s !== e) begin
			errors++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	// Holds valid between commands so back-to-back offers stay legal
	task automatic send(input row_t r);
		cmd_valid = 1;
		cmd_write = r.w;
		cmd_addr = r.a;
		cmd_wdata = r.d;
		cmd_bytes = r.b;
		#1;
		while (!(cmd_ready && ce)) @(negedge mclk);
		@(negedge mclk);
	endtask
	task automatic get(output logic [DATA_W-1:0] x);
		while (rdq.size() == 0) @(negedge mclk);
		x = rdq.pop_front();
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		{resetn, cmd_valid, cmd_write, sleep_in, test_clk} = 0;
		{test_mode_select, cmd_addr, cmd_wdata, cmd_bytes} = 0;
		ce = 1;
		order_sel = 1;
		repeat (3) @(negedge mclk);
		chk("mem_oe_n", 1, pins.mem_oe_n);
		chk("host_oe_n", 1, pins.host_oe_n);
		chk("rd_valid", 0, rd_valid);
		resetn = 1;
		$display("test reset done");
		foreach (rows[i]) send(rows[i]);
		cmd_valid = 0;
		foreach (rows[i]) if (!rows[i].w) begin
			get(v);
			chk("rd_data", rows[i].d, v);
		end
		$display("test rows done");
		sleep_in = 1;
		repeat (5) @(negedge mclk);
		chk("sleeping", 1, sleeping);
		cmd_valid = 1;
		cmd_write = 0;
		cmd_addr = rows[6].a;
		k = 0;
		#1;
		while (cmd_ready === 1'b1 && k < 40) begin
			k++;
			@(negedge mclk);
			#1;
		end
		cmd_valid = 0;
		chk("fill", FIFO_DEPTH, k);
		sleep_in = 0;
		repeat (FIFO_DEPTH) begin
			get(v);
			chk("drain", rows[6].d, v);
		end
		chk("sleeping", 0, sleeping);
		$display("test sleep done");
		// Offer a read while frozen; it must wait for the enable
		ce = 0;
		cmd_valid = 1;
		cmd_write = 0;
		cmd_addr = rows[5].a;
		repeat (6) @(negedge mclk);
		chk("frozen", 0, rdq.size());
		ce = 1;
		@(negedge mclk);
		cmd_valid = 0;
		get(v);
		chk("resume", rows[5].d, v);
		$display("test freeze done");
		test_mode_select = 1;
		repeat (3) begin
			#5 test_clk = 1;
			#5 test_clk = 0;
		end
		chk("test_state", 3, test_state);
		$display("test port done");
		end_sim();
	end
endmodule // pipelined_burst_sram_access_tb
